/* core/rdp_regs.vh */
`ifndef RDP_REGS_VH
`define RDP_REGS_VH

// Register bus shape.
`define RDP_ADDR_W 4
`define RDP_DATA_W 16

// Register offsets on the plain register port.
`define RDP_REG_CTRL 4'h0
`define RDP_REG_MODE 4'h1
`define RDP_REG_TEST 4'h2
`define RDP_REG_STAT 4'h3

// Control register field positions.
`define RDP_CTRL_PH_MODE 0
`define RDP_CTRL_PH_SEL 1
`define RDP_CTRL_STD_SEL 2
`define RDP_CTRL_SOFT 3
`define RDP_CTRL_STRICT 4
`define RDP_CTRL_SYR 5
`define RDP_CTRL_W 6

// Output mode register field positions.
`define RDP_MODE_BIT_A 0
`define RDP_MODE_BIT_B 1
`define RDP_MODE_POL 2
`define RDP_MODE_W 3

// Test configuration width.
`define RDP_TEST_W 4

// Reset values.
`define RDP_CTRL_RST 6'h02
`define RDP_MODE_RST 3'h3
`define RDP_TEST_RST 4'h0

// Output mode codes.
`define RDP_BASE_OFF 2'h0
`define RDP_BASE_CLK 2'h1
`define RDP_BASE_CAR 2'h2
`define RDP_BASE_ERR 2'h3
`define RDP_MODE_CNT 3'h4

// Block error class codes from the corrector.
`define RDP_CLS_NONE 2'h0
`define RDP_CLS_CORR 2'h1
`define RDP_CLS_UNCORR 2'h2

// Error count window and thresholds.
`define RDP_ERR_WIN 48
`define RDP_ERR_LVL1 6'h14
`define RDP_ERR_LVL2 6'h28

// Timing.
`define RDP_CLK_PERIOD_NS 10
`define RDP_SYNC_PULSE_US 421
// Sync pulse length in system clocks: 421 us at a 10 ns period.
`define RDP_SYNC_PULSE_CYC 16'ha474

`endif

/* core/rdp_sync3.v */
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; a bit changes once stages two and three agree.
module rdp_sync3 #(
	parameter W = 1
) (
	input wire ref_clk,
	input wire nrst,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);

	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	// The first stage feeds only the second, to keep metastability contained.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= (s2 & s3) | (dout & (s2 ^ s3));
		end
	end

endmodule

`default_nettype wire

/* core/rdp_pin_cfg.v */
// How it works
// - Phase mode 0: follow detected traffic subcarrier, steer demodulation phase automatically.
// - In automatic mode the phase after a sync reset comes from phase select.
// - Phase mode 1 fixes phase: 90 degrees for select 0, 0 degrees for 1.
// - Power-on: phase mode 0, phase select 1.
// - Standard select 0 decodes basic only; 1 also detects offset word E.
// - Three-bit output mode assigns the auxiliary pin functions.
// - Power-on output mode is 3 with polarity select 0.
// - Polarity select 1 makes clock, error, carrier, sync, presence pins active high.
// - Data and soft outputs change on clock pin rise, or fall when inverted.
// - Mode 2 carrier pin high without subcarrier, low with it.
// - Mode 3 error/corrected pins encode uncorrectable, corrected, error-free block.
// - Mode 4 count pins grade errored blocks among the last 48; fixed polarity.
// - Modes 0 to 2: sync pin low when synchronized, high otherwise.
// - Mode 3: sync pin pulses high 421 us per block when synchronized.
// - Sync pin shows the synchronization state of the previous block.
// - Presence pin high without data signal, low when detected.
// - Test pins low: normal; first low, second high: standby with oscillator stopped.
// - Soft flag control eases soft output; strict control tightens presence detection.
// - Sync reset holds the detector unsynchronized until released.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rdp_regs.vh"

module rdp_pin_cfg #(
	parameter [15:0] SYNC_PULSE_CYC = `RDP_SYNC_PULSE_CYC
) (
	input wire ref_clk,
	input wire nrst,
	input wire [`RDP_ADDR_W-1:0] addr,
	input wire [`RDP_DATA_W-1:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [`RDP_DATA_W-1:0] rdata,
	input wire rec_clk_pin,
	input wire rec_data_pin,
	input wire rec_soft_pin,
	input wire test_pin_first,
	input wire test_pin_second,
	input wire sync_reset_pin,
	input wire blk_valid,
	input wire [1:0] blk_class,
	input wire blk_had_err,
	input wire synced_in,
	input wire subcarrier_tone,
	input wire carrier57_in,
	input wire data_detect_in,
	output reg demod_phase_zero,
	output reg ext_offset_en,
	output reg soft_flag_ctrl,
	output reg presence_strict_ctrl,
	output reg sync_hold,
	output reg standby,
	output reg pin_drive_o,
	output reg recovered_clock_out_oe_n,
	output reg recovered_data_out_oe_n,
	output reg soft_decision_out_oe_n,
	output reg aux_pin_f_oe_n,
	output reg aux_pin_g_oe_n,
	output reg sync_pin_oe_n,
	output reg data_presence_out_oe_n
);

	reg [`RDP_CTRL_W-1:0] ctrl;
	reg [`RDP_MODE_W-1:0] out_mode;
	reg [`RDP_TEST_W-1:0] test_cfg;
	wire [2:0] link_f;
	wire [2:0] pins_f;
	wire rclk_f;
	wire rdata_f;
	wire rsoft_f;
	reg rclk_prev;
	reg data_q;
	reg soft_q;
	reg tone_prev;
	reg auto_phase;
	reg prev_sync;
	reg [15:0] pulse_cnt;
	reg [1:0] cls_q;
	reg [`RDP_ERR_WIN-1:0] err_hist;
	reg [5:0] err_cnt;
	reg [1:0] err_grade;
	wire phase_mode_bit;
	wire phase_select_bit;
	wire out_mode_bit_a;
	wire out_mode_bit_b;
	wire polarity_select_bit;
	wire [1:0] base;
	wire is_cnt;
	wire clk_en;
	reg next_f_lvl;
	reg next_g_lvl;
	reg next_f_en;
	reg next_g_en;
	reg next_sync_lvl;

	assign phase_mode_bit = ctrl[`RDP_CTRL_PH_MODE];
	assign phase_select_bit = ctrl[`RDP_CTRL_PH_SEL];
	assign out_mode_bit_a = out_mode[`RDP_MODE_BIT_A];
	assign out_mode_bit_b = out_mode[`RDP_MODE_BIT_B];
	assign polarity_select_bit = out_mode[`RDP_MODE_POL];
	assign base = {out_mode_bit_b, out_mode_bit_a};
	assign is_cnt = (out_mode == `RDP_MODE_CNT);
	assign clk_en = (base != `RDP_BASE_OFF);

	// Link pins arrive on the demodulator's bit clock, so they are filtered together.
	rdp_sync3 #(
		.W(3)
	) u_link_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.din({rec_soft_pin, rec_data_pin, rec_clk_pin}),
		.dout(link_f)
	);

	// Static board pins and the external sync reset pass the same filter.
	rdp_sync3 #(
		.W(3)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.din({sync_reset_pin, test_pin_second, test_pin_first}),
		.dout(pins_f)
	);

	assign rclk_f = link_f[0];
	assign rdata_f = link_f[1];
	assign rsoft_f = link_f[2];

	// Register writes; each field is latched by the write edge; the control and mode fields steer logic after it.
	// latch then apply
	always @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl <= `RDP_CTRL_RST;
			out_mode <= `RDP_MODE_RST;
			test_cfg <= `RDP_TEST_RST;
		end else if (wr_en) begin
			if (addr == `RDP_REG_CTRL) begin
				ctrl <= wdata[`RDP_CTRL_W-1:0];
			end else if (addr == `RDP_REG_MODE) begin
				out_mode <= wdata[`RDP_MODE_W-1:0];
			end else if (addr == `RDP_REG_TEST) begin
				test_cfg <= wdata[`RDP_TEST_W-1:0];
			end
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped reads give zero.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else if (rd_en) begin
			if (addr == `RDP_REG_CTRL) begin
				rdata <= {10'h000, ctrl};
			end else if (addr == `RDP_REG_MODE) begin
				rdata <= {13'h0000, out_mode};
			end else if (addr == `RDP_REG_TEST) begin
				rdata <= {12'h000, test_cfg};
			end else if (addr == `RDP_REG_STAT) begin
				rdata <= {4'h0, err_cnt, cls_q, standby, sync_hold, prev_sync, demod_phase_zero};
			end else begin
				rdata <= 16'h0000;
			end
		end else begin
			rdata <= 16'h0000;
		end
	end

	// Control outputs to the decoder core, registered so they follow the latched fields and the filtered pins.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			ext_offset_en <= 1'b0;
			soft_flag_ctrl <= 1'b0;
			presence_strict_ctrl <= 1'b0;
			sync_hold <= 1'b0;
			standby <= 1'b0;
		end else begin
			ext_offset_en <= ctrl[`RDP_CTRL_STD_SEL];
			soft_flag_ctrl <= ctrl[`RDP_CTRL_SOFT];
			presence_strict_ctrl <= ctrl[`RDP_CTRL_STRICT];
			sync_hold <= ctrl[`RDP_CTRL_SYR] | pins_f[2];
			standby <= ~pins_f[0] & pins_f[1];
		end
	end

	// Automatic phase tracks changes of the subcarrier detector; a sync reset reseeds it.
	// Reacting to changes only keeps the seeded phase until the detector reports otherwise.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			tone_prev <= 1'b0;
			auto_phase <= 1'b1;
			demod_phase_zero <= 1'b1;
		end else begin
			tone_prev <= subcarrier_tone;
			if (sync_hold) begin
				auto_phase <= phase_select_bit;
			end else if (subcarrier_tone != tone_prev) begin
				auto_phase <= subcarrier_tone;
			end
			demod_phase_zero <= phase_mode_bit ? phase_select_bit : auto_phase;
		end
	end

	// Data and soft bits move on the recovered clock's rise; the clock pin is inverted
	// with polarity select, so the pin edge seen outside flips with it.
	// update on clock edge
	always @(posedge ref_clk) begin
		if (!nrst) begin
			rclk_prev <= 1'b0;
			data_q <= 1'b0;
			soft_q <= 1'b0;
		end else begin
			rclk_prev <= rclk_f;
			if (rclk_f && !rclk_prev) begin
				data_q <= rdata_f;
				soft_q <= rsoft_f;
			end
		end
	end

	// Per-block status: previous sync state, error class, and the sync pulse timer.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			prev_sync <= 1'b0;
			cls_q <= `RDP_CLS_NONE;
			pulse_cnt <= 16'h0000;
		end else begin
			if (blk_valid) begin
				prev_sync <= synced_in & ~sync_hold;
				cls_q <= blk_class;
				pulse_cnt <= (synced_in & ~sync_hold) ? SYNC_PULSE_CYC : 16'h0000;
			end else if (sync_hold) begin
				prev_sync <= 1'b0;
				pulse_cnt <= 16'h0000;
			end else if (pulse_cnt != 16'h0000) begin
				pulse_cnt <= pulse_cnt - 16'h0001;
			end
		end
	end

	// Sliding window over the last blocks; the count adds the newest and drops the oldest.
	// errored block count
	always @(posedge ref_clk) begin
		if (!nrst) begin
			err_hist <= {`RDP_ERR_WIN{1'b0}};
			err_cnt <= 6'h00;
		end else if (blk_valid) begin
			err_hist <= {err_hist[`RDP_ERR_WIN-2:0], blk_had_err};
			err_cnt <= err_cnt + {5'h00, blk_had_err} - {5'h00, err_hist[`RDP_ERR_WIN-1]};
		end
	end

	// Grade the count into the two-pin code.
	always @* begin
		if (err_cnt == 6'h00) begin
			err_grade = 2'h0;
		end else if (err_cnt <= `RDP_ERR_LVL1) begin
			err_grade = 2'h1;
		end else if (err_cnt <= `RDP_ERR_LVL2) begin
			err_grade = 2'h2;
		end else begin
			err_grade = 2'h3;
		end
	end

	// Function of the two shared pins and the sync pin level for the selected mode.
	// pin function select
	always @* begin
		next_f_lvl = 1'b1;
		next_g_lvl = 1'b1;
		next_f_en = 1'b0;
		next_g_en = 1'b0;
		if (is_cnt) begin
			next_f_en = 1'b1;
			next_g_en = 1'b1;
			next_f_lvl = err_grade[1];
			next_g_lvl = err_grade[0];
		end else if (base == `RDP_BASE_CAR) begin
			next_f_en = 1'b1;
			next_g_en = 1'b1;
			next_f_lvl = carrier57_in ^ polarity_select_bit;
			next_g_lvl = ~subcarrier_tone ^ polarity_select_bit;
		end else if (base == `RDP_BASE_ERR) begin
			next_f_en = 1'b1;
			next_g_en = 1'b1;
			next_f_lvl = (cls_q != `RDP_CLS_UNCORR) ^ polarity_select_bit;
			next_g_lvl = (cls_q == `RDP_CLS_NONE) ^ polarity_select_bit;
		end
		if (base == `RDP_BASE_ERR) begin
			next_sync_lvl = ~prev_sync | (pulse_cnt != 16'h0000);
		end else begin
			next_sync_lvl = ~prev_sync;
		end
	end

	// Pin stage: an open-drain pin is released when its level is high or it is unused.
	// Registering here keeps every pin glitch-free at one cycle of added latency.
	// unused pins released
	always @(posedge ref_clk) begin
		if (!nrst) begin
			pin_drive_o <= 1'b0;
			recovered_clock_out_oe_n <= 1'b1;
			recovered_data_out_oe_n <= 1'b1;
			soft_decision_out_oe_n <= 1'b1;
			aux_pin_f_oe_n <= 1'b1;
			aux_pin_g_oe_n <= 1'b1;
			sync_pin_oe_n <= 1'b1;
			data_presence_out_oe_n <= 1'b1;
		end else begin
			pin_drive_o <= 1'b0;
			recovered_clock_out_oe_n <= ~clk_en | (rclk_f ^ polarity_select_bit);
			recovered_data_out_oe_n <= ~clk_en | data_q;
			soft_decision_out_oe_n <= ~clk_en | soft_q;
			aux_pin_f_oe_n <= ~next_f_en | next_f_lvl;
			aux_pin_g_oe_n <= ~next_g_en | next_g_lvl;
			sync_pin_oe_n <= next_sync_lvl ^ polarity_select_bit;
			data_presence_out_oe_n <= ~data_detect_in ^ polarity_select_bit;
		end
	end

endmodule

`default_nettype wire

/* bench/rdp_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdp_regs.vh"
module rdp_checker (
	input wire ref_clk,
	input wire nrst,
	input wire [`RDP_ADDR_W-1:0] addr,
	input wire [`RDP_DATA_W-1:0] wdata,
	input wire wr_en,
	input wire blk_valid,
	input wire [1:0] blk_class,
	input wire test_pin_first,
	input wire test_pin_second,
	input wire data_detect_in,
	input wire demod_phase_zero,
	input wire ext_offset_en,
	input wire soft_flag_ctrl,
	input wire presence_strict_ctrl,
	input wire sync_hold,
	input wire standby,
	input wire recovered_clock_out_oe_n,
	input wire recovered_data_out_oe_n,
	input wire soft_decision_out_oe_n,
	input wire aux_pin_f_oe_n,
	input wire aux_pin_g_oe_n,
	input wire data_presence_out_oe_n
);
	reg [2:0] md;
	wire wc = wr_en && addr == `RDP_REG_CTRL;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// Mirror of the mode field; it moves at the same edge as the register.
	always @(posedge ref_clk) begin
		if (!nrst)
			md <= 3'h3;
		else if (wr_en && addr == `RDP_REG_MODE)
			md <= wdata[2:0];
	end
	a_phase_fixed: assert property (wc && wdata[0] ##1 !wc |=> demod_phase_zero == $past(wdata[1], 2))
		else $error("fixed phase wrong");
	a_ctrl_copy: assert property (wc ##1 !wc |=> {presence_strict_ctrl, soft_flag_ctrl, ext_offset_en} == $past(wdata[4:2], 2))
		else $error("control copy wrong");
	a_sync_hold: assert property (wc && wdata[5] ##1 !wc |=> sync_hold)
		else $error("sync hold missing");
	a_standby_pins: assert property ($stable({test_pin_first, test_pin_second}) [*8] |-> standby == (!test_pin_first && test_pin_second))
		else $error("standby wrong");
	a_class_pins: assert property (blk_valid && md == 3'h3 && !wr_en ##1 !blk_valid && !wr_en |=>
		{aux_pin_f_oe_n, aux_pin_g_oe_n} == {$past(blk_class, 2) != `RDP_CLS_UNCORR, $past(blk_class, 2) == `RDP_CLS_NONE})
		else $error("class pins wrong");
	a_mode_off: assert property ((md == 3'h0) [*3] |-> &{recovered_clock_out_oe_n, recovered_data_out_oe_n,
		soft_decision_out_oe_n, aux_pin_f_oe_n, aux_pin_g_oe_n})
		else $error("mode 0 pin driven");
	a_count_only: assert property ((md == 3'h4) [*3] |-> &{recovered_clock_out_oe_n, recovered_data_out_oe_n, soft_decision_out_oe_n})
		else $error("mode 4 pin driven");
	a_presence_pin: assert property ($stable({data_detect_in, md}) [*3] |-> data_presence_out_oe_n == (data_detect_in == md[2]))
		else $error("presence pin wrong");
	c_pulse: cover property (md == 3'h3 && blk_valid);
	c_count: cover property (md == 3'h4 && blk_valid);
	c_standby: cover property (standby);
endmodule
bind rdp_pin_cfg rdp_checker u_rdp_checker (.ref_clk, .nrst, .addr, .wdata, .wr_en, .blk_valid, .blk_class,
	.test_pin_first, .test_pin_second, .data_detect_in, .demod_phase_zero, .ext_offset_en, .soft_flag_ctrl,
	.presence_strict_ctrl, .sync_hold, .standby, .recovered_clock_out_oe_n, .recovered_data_out_oe_n,
	.soft_decision_out_oe_n, .aux_pin_f_oe_n, .aux_pin_g_oe_n, .data_presence_out_oe_n);
`default_nettype wire

/* bench/rdp_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rdp_link_model (
	input wire logic go,
	input wire logic pol,
	input wire logic [7:0] pat,
	input wire logic clk_pin,
	input wire logic data_pin,
	input wire logic soft_pin,
	output logic rclk,
	output logic rdat,
	output logic rsoft,
	output int nbits,
	output int nbad
);
	logic [1:0] q [$];
	logic [1:0] ev;
	initial begin
		rclk = 1'h0;
		rdat = 1'h0;
		rsoft = 1'h0;
		nbits = 0;
		nbad = 0;
	end
	// Eight bits per frame; data moves while the clock is low, and the clock rests low between frames.
	always @(posedge go) begin
		for (int i = 0; i < 8; i++) begin
			rdat = pat[i];
			rsoft = pat[7 - i];
			#62.5 rclk = 1'h1;
			q.push_back({pat[7 - i], pat[i]});
			#62.5 rclk = 1'h0;
		end
		#62.5 rdat = ~rdat;
	end
	// sample edge
	// Bits are taken on the pin edge opposite to the one that moves them.
	always @(clk_pin) begin
		if (clk_pin === pol && q.size() > 0) begin
			ev = q.pop_front();
			nbits++;
			if ({soft_pin, data_pin} !== ev)
				nbad++;
		end
	end
endmodule
`default_nettype wire

/* bench/test_rds_output_pin_and_demod_config.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdp_regs.vh"
module test_rds_output_pin_and_demod_config;
	localparam int P = 20;
	logic ref_clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0, blk_valid = 1'h0, blk_had_err = 1'h0;
	logic synced_in = 1'h0, subcarrier_tone = 1'h0, carrier57_in = 1'h0, data_detect_in = 1'h0;
	logic test_pin_first = 1'h0, test_pin_second = 1'h0, sync_reset_pin = 1'h0, go = 1'h0, pol = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [1:0] blk_class = 2'h0;
	wire [15:0] rdata;
	wire rec_clk_pin, rec_data_pin, rec_soft_pin, demod_phase_zero, ext_offset_en, soft_flag_ctrl;
	wire presence_strict_ctrl, sync_hold, standby, recovered_clock_out_oe_n, recovered_data_out_oe_n;
	wire soft_decision_out_oe_n, aux_pin_f_oe_n, aux_pin_g_oe_n, sync_pin_oe_n, data_presence_out_oe_n, pin_drive_o;
	int nbits, nbad, err_total = 0, n_compared = 0;
	int nb [8] = '{48, 1, 19, 1, 19, 1, 7, 48};
	logic [1:0] ex [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
	// System clock at 100 MHz.
	always #5 ref_clk = ~ref_clk;
	rdp_pin_cfg #(.SYNC_PULSE_CYC(16'(P))) u_rdp_pin_cfg (.ref_clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata,
		.rec_clk_pin, .rec_data_pin, .rec_soft_pin, .test_pin_first, .test_pin_second, .sync_reset_pin,
		.blk_valid, .blk_class, .blk_had_err, .synced_in, .subcarrier_tone, .carrier57_in, .data_detect_in,
		.demod_phase_zero, .ext_offset_en, .soft_flag_ctrl, .presence_strict_ctrl, .sync_hold, .standby,
		.pin_drive_o, .recovered_clock_out_oe_n, .recovered_data_out_oe_n, .soft_decision_out_oe_n,
		.aux_pin_f_oe_n, .aux_pin_g_oe_n, .sync_pin_oe_n, .data_presence_out_oe_n);
	rdp_link_model u_rdp_link_model (.go, .pol, .pat(8'h4d), .clk_pin(recovered_clock_out_oe_n),
		.data_pin(recovered_data_out_oe_n), .soft_pin(soft_decision_out_oe_n), .rclk(rec_clk_pin),
		.rdat(rec_data_pin), .rsoft(rec_soft_pin), .nbits, .nbad);
	task chk(input string nm, input logic [15:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge ref_clk);
		wr_en <= 1'h0;
	endtask
	task rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge ref_clk);
		rd_en <= 1'h0;
		#1 chk(nm, rdata, e);
	endtask
	// One block boundary; returns when its pins have settled.
	task blk(input logic s, input logic [1:0] c, input logic e);
		@(posedge ref_clk);
		blk_valid <= 1'h1;
		synced_in <= s;
		blk_class <= c;
		blk_had_err <= e;
		@(posedge ref_clk);
		blk_valid <= 1'h0;
		cyc(2);
	endtask
	task t_regs;
		chk("ph", demod_phase_zero, 1'h1);
		chk("drv", pin_drive_o, 1'h0);
		rdc("ctrl", `RDP_REG_CTRL, 16'h0002);
		rdc("mode", `RDP_REG_MODE, 16'h0003);
		rdc("test", `RDP_REG_TEST, 16'h0000);
		wr(`RDP_REG_TEST, 16'h0000);
		wr(`RDP_REG_CTRL, 16'h001e);
		cyc(2);
		chk("cfg", {presence_strict_ctrl, soft_flag_ctrl, ext_offset_en}, 3'h7);
		wr(4'h9, 16'h0021);
		rdc("ctrl", `RDP_REG_CTRL, 16'h001e);
		rdc("none", 4'h9, 16'h0000);
	endtask
	task t_phase;
		wr(`RDP_REG_CTRL, 16'h0001);
		cyc(2);
		chk("ph", demod_phase_zero, 1'h0);
		wr(`RDP_REG_CTRL, 16'h0003);
		cyc(2);
		chk("ph", demod_phase_zero, 1'h1);
		wr(`RDP_REG_CTRL, 16'h0020);
		cyc(2);
		chk("hold", sync_hold, 1'h1);
		// The seed reaches the phase output two cycles after the hold rises.
		cyc(1);
		chk("ph", demod_phase_zero, 1'h0);
		wr(`RDP_REG_CTRL, 16'h0000);
		@(posedge ref_clk) subcarrier_tone <= 1'h1;
		cyc(4);
		chk("ph", demod_phase_zero, 1'h1);
		@(posedge ref_clk) subcarrier_tone <= 1'h0;
		sync_reset_pin <= 1'h1;
		cyc(8);
		chk("ph", demod_phase_zero, 1'h0);
		chk("hold", sync_hold, 1'h1);
		@(posedge ref_clk) sync_reset_pin <= 1'h0;
		cyc(8);
		chk("hold", sync_hold, 1'h0);
	endtask
	task t_modes;
		for (int m = 0; m < 8; m++) begin
			wr(`RDP_REG_MODE, 16'(m));
			@(posedge ref_clk) data_detect_in <= m[0];
			subcarrier_tone <= m[1];
			carrier57_in <= m[1];
			cyc(6);
			chk("clk", recovered_clock_out_oe_n, m[1:0] == 0 || m[2]);
			chk("pres", data_presence_out_oe_n, m[0] == m[2]);
			chk("sync", sync_pin_oe_n, !m[2]);
			if (m[1:0] == 2'h2) begin
				chk("ari", aux_pin_g_oe_n, m[2]);
				chk("57k", aux_pin_f_oe_n, !m[2]);
			end
		end
	endtask
	task t_class;
		wr(`RDP_REG_MODE, 16'h0003);
		for (int c = 0; c < 3; c++) begin
			blk(1'h0, 2'(c), 1'h0);
			chk("cls", {aux_pin_f_oe_n, aux_pin_g_oe_n}, {c != 2, c == 0});
		end
	endtask
	task t_sync;
		int n;
		wr(`RDP_REG_MODE, 16'h0001);
		@(posedge ref_clk) synced_in <= 1'h1;
		cyc(4);
		chk("sync", sync_pin_oe_n, 1'h1);
		blk(1'h1, 2'h0, 1'h0);
		chk("sync", sync_pin_oe_n, 1'h0);
		wr(`RDP_REG_MODE, 16'h0003);
		cyc(2);
		blk(1'h1, 2'h0, 1'h0);
		n = 0;
		while (sync_pin_oe_n === 1'h1 && n < 99) begin
			n++;
			cyc(1);
		end
		// The pin has already stood high for one cycle of the reloaded pulse when blk returns.
		chk("pulse", 16'(n), 16'(P - 1));
		blk(1'h0, 2'h0, 1'h0);
		chk("sync", sync_pin_oe_n, 1'h1);
	endtask
	task t_count;
		wr(`RDP_REG_MODE, 16'h0004);
		for (int i = 0; i < 8; i++) begin
			repeat (nb[i]) blk(1'h0, 2'h0, i > 0 && i < 7);
			chk("cnt", {aux_pin_f_oe_n, aux_pin_g_oe_n}, ex[i]);
			// All 48 blocks in the window errored; the phase output is at 0 degrees.
			if (i == 6)
				rdc("stat", `RDP_REG_STAT, 16'h0c01);
		end
	endtask
	task t_link;
		for (int p = 0; p < 2; p++) begin
			wr(`RDP_REG_MODE, p ? 16'h0005 : 16'h0001);
			@(posedge ref_clk) pol <= p[0];
			go <= 1'h1;
			cyc(120);
			chk("bits", 16'(nbits), 16'(8 * p + 8));
			chk("bad", 16'(nbad), 16'h0000);
			@(posedge ref_clk) go <= 1'h0;
		end
	endtask
	task t_standby;
		@(posedge ref_clk) test_pin_second <= 1'h1;
		cyc(8);
		chk("stby", standby, 1'h1);
		rdc("stat", `RDP_REG_STAT, 16'h0009);
		@(posedge ref_clk) test_pin_second <= 1'h0;
		cyc(8);
		chk("stby", standby, 1'h0);
	endtask
	task summarize;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Reset, then the scenarios in turn; later ones rely on the control and subcarrier state left behind.
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'h1;
		cyc(1);
		t_regs();
		t_phase();
		t_modes();
		t_class();
		t_sync();
		t_count();
		t_link();
		t_standby();
		summarize();
	end
	// The run needs about 10 us; a hang is cut off well past that.
	initial begin
		#200000;
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire
